// ---- core/ppe_pkg.sv ----
package ppe_pkg;
  localparam int DATA_W = 8;
  localparam int QUEUE_DEPTH = 4;
  localparam int CLK_MHZ = 100;
  // retry limit, counted in clocks of the core domain
  localparam int RETRY_CLKS = 16;
  localparam logic [4:0] RETRY_LIMIT = 5'h10;
  // response delays after a sampled BUSY or acknowledge change
  localparam logic [2:0] DLY_DSTB_REL = 3'h3;
  localparam logic [2:0] DLY_ASTB_WR_REL = 3'h4;
  localparam logic [2:0] DLY_ASTB_RD_REL = 3'h3;
  localparam logic [2:0] DLY_END = 3'h2;
  localparam logic [2:0] DLY_ECP_STB_REL = 3'h2;
  localparam logic [2:0] DLY_REV_ASSERT = 3'h3;
  localparam logic [2:0] DLY_REV_RELEASE = 3'h2;
  localparam logic [2:0] DLY_FILTER = 3'h2;
  localparam logic [7:0] DATA_RST = 8'h00;
  // synchronisers reset to the pin's idle level, so no false edge follows reset
  localparam logic BUSY_IDLE = 1'h0;
  localparam logic ACK_N_IDLE = 1'h1;

  typedef enum logic [1:0]
  {
    ACC_EPP_DATA = 2'h0,
    ACC_EPP_ADDR = 2'h1,
    ACC_ECP_QUEUE = 2'h2,
    ACC_NONE = 2'h3
  } acc_kind_t;

  typedef struct packed
  {
    logic valid;
    logic write;
    acc_kind_t kind;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed
  {
    logic done;
    logic retry;
    logic [7:0] rdata;
  } host_rsp_t;

  typedef struct packed
  {
    logic dataStbN;
    logic addrStbN;
    logic writeN;
    logic ackHsN;
    logic [7:0] dataOut;
    logic dataOe;
  } port_out_t;

  // gray sequence along the usual path
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h0,
    ST_STB = 4'h1,
    ST_RELWAIT = 4'h3,
    ST_BUSYLOW = 4'h2,
    ST_ENDWAIT = 4'h6,
    ST_REVWAIT = 4'h7,
    ST_REVHS = 4'h5,
    ST_REVEND = 4'h4
  } state_t;
endpackage

// ---- core/ppe_sync.sv ----
`timescale 1ns/100ps
module ppe_sync
#(
  parameter logic RESET_LEVEL = 1'h0
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);
  logic stage1_r;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_r <= RESET_LEVEL;
      dout <= RESET_LEVEL;
    end
    else
    begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end
endmodule

// ---- core/ppe_fifo.sv ----
`timescale 1ns/100ps
module ppe_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wrPtr_r] <= inData;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      if (pop)
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- core/parallel_port_engine.sv ----
`timescale 1ns/100ps
module parallel_port_engine
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic filterEn,
  input wire logic reverseMode,
  input wire ppe_pkg::host_req_t hostReq,
  output ppe_pkg::host_rsp_t hostRsp,
  input wire logic busyPin,
  input wire logic ackNPin,
  input wire logic [7:0] dataIn,
  output ppe_pkg::port_out_t portOut,
  output logic fwdQueueReady
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic busySync;
  logic ackNSync;

  ppe_sync #(.RESET_LEVEL(ppe_pkg::BUSY_IDLE)) u_sync_busy
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(busyPin),
    .dout(busySync)
  );

  ppe_sync #(.RESET_LEVEL(ppe_pkg::ACK_N_IDLE)) u_sync_ack
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(ackNPin),
    .dout(ackNSync)
  );

  // ************************************************************
  // queues: forward toward the port, reverse toward the host
  // ************************************************************
  logic fwdInValid;
  logic fwdInReady;
  logic fwdOutValid;
  logic fwdOutReady;
  logic [7:0] fwdOutData;
  logic revInValid;
  logic revInReady;
  logic revOutValid;
  logic revOutReady;
  logic [7:0] revOutData;

  assign fwdInValid = hostReq.valid && hostReq.write && hostReq.kind == ppe_pkg::ACC_ECP_QUEUE
    && !hostRsp.done;
  assign revOutReady = hostReq.valid && !hostReq.write
    && hostReq.kind == ppe_pkg::ACC_ECP_QUEUE && !hostRsp.done;

  ppe_fifo #(.WIDTH(ppe_pkg::DATA_W), .DEPTH(ppe_pkg::QUEUE_DEPTH)) u_fwd_queue
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .inValid(fwdInValid),
    .inReady(fwdInReady),
    .inData(hostReq.wdata),
    .outValid(fwdOutValid),
    .outReady(fwdOutReady),
    .outData(fwdOutData)
  );

  ppe_fifo #(.WIDTH(ppe_pkg::DATA_W), .DEPTH(ppe_pkg::QUEUE_DEPTH)) u_rev_queue
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .inValid(revInValid),
    .inReady(revInReady),
    .inData(dataIn),
    .outValid(revOutValid),
    .outReady(revOutReady),
    .outData(revOutData)
  );

  // ************************************************************
  // port sequencer
  // ************************************************************
  ppe_pkg::state_t state_r;
  ppe_pkg::acc_kind_t curKind_r;
  logic curWrite_r;
  logic [2:0] wait_r;
  logic eppBusy;
  logic eppDone_r;
  logic [7:0] eppRdata_r;
  logic [2:0] extra;
  logic waitDone;
  logic eppReq;
  logic startEpp;
  logic startFwd;

  assign extra = filterEn ? ppe_pkg::DLY_FILTER : 3'h0;
  assign waitDone = (wait_r == 3'h1);
  assign eppReq = hostReq.valid && hostReq.kind != ppe_pkg::ACC_ECP_QUEUE
    && hostReq.kind != ppe_pkg::ACC_NONE;
  assign eppBusy = (state_r != ppe_pkg::ST_IDLE) && curKind_r != ppe_pkg::ACC_ECP_QUEUE;
  // a pending retry result blocks a second cycle for the same access
  assign startEpp = eppReq && state_r == ppe_pkg::ST_IDLE && !eppDone_r;
  assign startFwd = !startEpp && !reverseMode && fwdOutValid && state_r == ppe_pkg::ST_IDLE;
  assign fwdOutReady = startFwd;
  assign revInValid = state_r == ppe_pkg::ST_REVEND && waitDone;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ppe_pkg::ST_IDLE;
      curKind_r <= ppe_pkg::ACC_NONE;
      curWrite_r <= 1'b0;
      wait_r <= 3'h0;
    end
    else
    begin
      if (wait_r != 3'h0)
        wait_r <= wait_r - 3'h1;
      case (state_r)
        ppe_pkg::ST_IDLE:
        begin
          if (startEpp)
          begin
            state_r <= ppe_pkg::ST_STB;
            curKind_r <= hostReq.kind;
            curWrite_r <= hostReq.write;
          end
          else if (startFwd)
          begin
            state_r <= ppe_pkg::ST_STB;
            curKind_r <= ppe_pkg::ACC_ECP_QUEUE;
            curWrite_r <= 1'b1;
          end
          else if (reverseMode && !ackNSync && revInReady)
          begin
            state_r <= ppe_pkg::ST_REVWAIT;
            wait_r <= ppe_pkg::DLY_REV_ASSERT + extra;
          end
        end
        ppe_pkg::ST_STB:
        begin
          if (busySync)
          begin
            state_r <= ppe_pkg::ST_RELWAIT;
            if (curKind_r == ppe_pkg::ACC_ECP_QUEUE)
              wait_r <= ppe_pkg::DLY_ECP_STB_REL + extra;
            else if (curKind_r == ppe_pkg::ACC_EPP_ADDR && curWrite_r)
              wait_r <= ppe_pkg::DLY_ASTB_WR_REL + extra;
            else if (curKind_r == ppe_pkg::ACC_EPP_ADDR)
              wait_r <= ppe_pkg::DLY_ASTB_RD_REL + extra;
            else
              wait_r <= ppe_pkg::DLY_DSTB_REL + extra;
          end
        end
        ppe_pkg::ST_RELWAIT:
        begin
          if (waitDone)
            state_r <= ppe_pkg::ST_BUSYLOW;
        end
        ppe_pkg::ST_BUSYLOW:
        begin
          if (!busySync)
          begin
            state_r <= ppe_pkg::ST_ENDWAIT;
            wait_r <= ppe_pkg::DLY_END + extra;
          end
        end
        ppe_pkg::ST_ENDWAIT:
        begin
          if (waitDone)
            state_r <= ppe_pkg::ST_IDLE;
        end
        ppe_pkg::ST_REVWAIT:
        begin
          if (waitDone)
            state_r <= ppe_pkg::ST_REVHS;
        end
        ppe_pkg::ST_REVHS:
        begin
          if (ackNSync)
          begin
            state_r <= ppe_pkg::ST_REVEND;
            wait_r <= ppe_pkg::DLY_REV_RELEASE + extra;
          end
        end
        ppe_pkg::ST_REVEND:
        begin
          if (waitDone)
            state_r <= ppe_pkg::ST_IDLE;
        end
        default:
          state_r <= ppe_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // port pins, all registered
  // ************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      portOut.dataStbN <= 1'b1;
      portOut.addrStbN <= 1'b1;
      portOut.writeN <= 1'b1;
      portOut.ackHsN <= 1'b1;
      portOut.dataOut <= ppe_pkg::DATA_RST;
      portOut.dataOe <= 1'b0;
    end
    else
    begin
      if (startEpp)
      begin
        portOut.dataStbN <= hostReq.kind != ppe_pkg::ACC_EPP_DATA;
        portOut.addrStbN <= hostReq.kind != ppe_pkg::ACC_EPP_ADDR;
        portOut.writeN <= !hostReq.write;
        portOut.dataOut <= hostReq.wdata;
        portOut.dataOe <= hostReq.write;
      end
      else if (startFwd)
      begin
        portOut.writeN <= 1'b0;
        portOut.dataOut <= fwdOutData;
        portOut.dataOe <= 1'b1;
      end
      else if (state_r == ppe_pkg::ST_RELWAIT && waitDone)
      begin
        portOut.dataStbN <= 1'b1;
        portOut.addrStbN <= 1'b1;
        if (curKind_r == ppe_pkg::ACC_ECP_QUEUE)
          portOut.writeN <= 1'b1;
      end
      else if (state_r == ppe_pkg::ST_ENDWAIT && waitDone)
      begin
        portOut.writeN <= 1'b1;
        portOut.dataOe <= 1'b0;
      end
      else if (state_r == ppe_pkg::ST_REVWAIT && waitDone)
        portOut.ackHsN <= 1'b0;
      else if (state_r == ppe_pkg::ST_REVEND && waitDone)
        portOut.ackHsN <= 1'b1;
    end
  end

  // ************************************************************
  // host answer: retry after the limit, data on the repeat
  // ************************************************************
  logic [4:0] holdCnt_r;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      eppDone_r <= 1'b0;
      eppRdata_r <= ppe_pkg::DATA_RST;
    end
    else
    begin
      if (eppBusy && state_r == ppe_pkg::ST_ENDWAIT && waitDone)
      begin
        eppDone_r <= 1'b1;
        if (!curWrite_r)
          eppRdata_r <= dataIn;
      end
      else if (eppBusy && state_r == ppe_pkg::ST_BUSYLOW && !busySync && !curWrite_r)
        eppRdata_r <= dataIn;
      else if (eppReq && eppDone_r && !hostRsp.done)
        eppDone_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      holdCnt_r <= 5'h0;
      hostRsp <= '0;
      fwdQueueReady <= 1'b0;
    end
    else
    begin
      hostRsp <= '0;
      fwdQueueReady <= fwdInReady;
      if (!eppReq || !eppBusy)
        holdCnt_r <= 5'h0;
      else if (!hostRsp.retry)
        holdCnt_r <= holdCnt_r + 5'h1;
      if (hostReq.valid && hostReq.kind == ppe_pkg::ACC_ECP_QUEUE && !hostRsp.done)
      begin
        if (hostReq.write)
          hostRsp.done <= fwdInReady;
        else
        begin
          hostRsp.done <= 1'b1;
          hostRsp.rdata <= revOutValid ? revOutData : ppe_pkg::DATA_RST;
        end
      end
      else if (eppReq && eppDone_r && !hostRsp.done)
      begin
        hostRsp.done <= 1'b1;
        hostRsp.rdata <= eppRdata_r;
      end
      else if (eppReq && eppBusy && holdCnt_r == ppe_pkg::RETRY_LIMIT - 5'h1
        && !hostRsp.retry)
        hostRsp.retry <= 1'b1;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  retry_at_limit_a: assert property (@(posedge core_clk) disable iff (!rstn)
    hostRsp.retry |-> $past(eppBusy, 1) && $past(holdCnt_r, 1) == 5'h0F)
    else $error("retry without sixteen clocks pending");
  retry_keeps_cycle_a: assert property (@(posedge core_clk) disable iff (!rstn)
    hostRsp.retry |-> state_r != ppe_pkg::ST_IDLE || eppDone_r)
    else $error("retry aborted the port cycle");
  no_second_cycle_a: assert property (@(posedge core_clk) disable iff (!rstn)
    eppDone_r |=> portOut.dataStbN && portOut.addrStbN)
    else $error("second EPP cycle started");
  filter_delay_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_r == ppe_pkg::ST_BUSYLOW && !busySync && filterEn) |=> wait_r == 3'h4)
    else $error("filter delay missing");
  data_strobe_rel_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_r == ppe_pkg::ST_STB && busySync && curKind_r == ppe_pkg::ACC_EPP_DATA
      && !filterEn) |=> !portOut.dataStbN ##1 !portOut.dataStbN ##1 !portOut.dataStbN
      ##1 portOut.dataStbN)
    else $error("data strobe release off");
  addr_wr_rel_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_r == ppe_pkg::ST_STB && busySync && curKind_r == ppe_pkg::ACC_EPP_ADDR
      && curWrite_r && !filterEn) |=> !portOut.addrStbN [*4] ##1 portOut.addrStbN)
    else $error("address strobe release off");
  ecp_strobe_rel_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_r == ppe_pkg::ST_STB && busySync && curKind_r == ppe_pkg::ACC_ECP_QUEUE
      && !filterEn) |=> ##2 $rose(portOut.writeN))
    else $error("ECP strobe release off");
  rev_assert_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_r == ppe_pkg::ST_IDLE && reverseMode && !ackNSync && revInReady && !startEpp
      && !startFwd && !filterEn)
      |=> ##3 $fell(portOut.ackHsN))
    else $error("reverse handshake late");
  rev_release_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_r == ppe_pkg::ST_REVHS && ackNSync && !filterEn) |=> ##1 revInValid
      ##1 portOut.ackHsN)
    else $error("reverse release off");

  fwd_cover: cover property (@(posedge core_clk) disable iff (!rstn)
    startFwd ##[1:40] fwdInValid && state_r != ppe_pkg::ST_IDLE);
  retry_cover: cover property (@(posedge core_clk) disable iff (!rstn)
    hostRsp.retry ##[1:60] hostRsp.done);
  rev_cover: cover property (@(posedge core_clk) disable iff (!rstn) revInValid);
endmodule

// ---- dv/ppe_peripheral.sv ----
`timescale 1ns/100ps
// ****************************************
// peripheral side of the port handshake
// ****************************************
module ppe_peripheral
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire ppe_pkg::port_out_t portOut,
  input wire logic [3:0] dly,
  input wire logic revGo,
  input wire logic [7:0] txByte,
  output logic busyPin,
  output logic ackNPin,
  output logic [7:0] dataIn
);
  logic [1:0] ph, rph;
  logic [3:0] cnt;
  logic epp, eDrv, rDrv, anyLow, rel;
  logic [7:0] eVal, rVal;
  assign anyLow = !portOut.dataStbN || !portOut.addrStbN || !portOut.writeN;
  assign rel = portOut.dataStbN && portOut.addrStbN && (epp || portOut.writeN);
  // a released bus shows changed data, so a stale byte never passes for fresh
  assign dataIn = eDrv ? eVal : (rDrv ? rVal : ~(eVal ^ rVal));
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ph <= 2'h0;
      cnt <= 4'h0;
      epp <= 1'b0;
      eDrv <= 1'b0;
      eVal <= 8'h00;
      busyPin <= 1'b0;
    end
    else
    begin
      case (ph)
        2'h0:
          if (anyLow)
          begin
            ph <= 2'h1;
            cnt <= dly;
            epp <= !portOut.dataStbN || !portOut.addrStbN;
          end
        2'h1:
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else
          begin
            busyPin <= 1'b1;
            eDrv <= epp && portOut.writeN;
            eVal <= txByte;
            ph <= 2'h2;
          end
        2'h2:
          if (rel)
          begin
            cnt <= dly;
            ph <= 2'h3;
          end
        default:
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else if (busyPin)
          begin
            busyPin <= 1'b0;
            // read data held past the fall for the host synchroniser and capture
            cnt <= 4'h4;
          end
          else if (!anyLow || !epp)
          begin
            eDrv <= 1'b0;
            ph <= 2'h0;
          end
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rph <= 2'h0;
      ackNPin <= 1'b1;
      rDrv <= 1'b0;
      rVal <= 8'h00;
    end
    else
    begin
      case (rph)
        2'h0:
          if (revGo)
          begin
            ackNPin <= 1'b0;
            rDrv <= 1'b1;
            rVal <= txByte;
            rph <= 2'h1;
          end
        2'h1:
          if (!portOut.ackHsN)
          begin
            ackNPin <= 1'b1;
            rph <= 2'h2;
          end
        default:
          if (portOut.ackHsN)
          begin
            rDrv <= 1'b0;
            rph <= 2'h0;
          end
      endcase
    end
  end
endmodule

// ---- dv/parallel_port_engine_tb_top.sv ----
`timescale 1ns/100ps
module parallel_port_engine_tb_top;
  logic core_clk, rstn, filterEn, reverseMode, busyPin, ackNPin, revGo, fwdQueueReady;
  logic pBusy, pAck, sawFull, stbOe;
  logic [7:0] dataIn, txByte, stbData;
  logic [3:0] dly;
  logic [7:0] fwd[$];
  ppe_pkg::host_req_t hostReq;
  ppe_pkg::host_rsp_t hostRsp;
  ppe_pkg::port_out_t portOut, pOut;
  int mismatches, tests_run, cyc, stbFalls;
  int tBusyHi, tBusyLo, tAckLo, tAckHi, tRelD, tRelA, tRelW, tHsLo, tHsHi;
  parallel_port_engine u_parallel_port_engine (.core_clk(core_clk), .rstn(rstn),
    .filterEn(filterEn), .reverseMode(reverseMode), .hostReq(hostReq), .hostRsp(hostRsp),
    .busyPin(busyPin), .ackNPin(ackNPin), .dataIn(dataIn), .portOut(portOut),
    .fwdQueueReady(fwdQueueReady));
  ppe_peripheral u_ppe_peripheral (.core_clk(core_clk), .rstn(rstn), .portOut(portOut),
    .dly(dly), .revGo(revGo), .txByte(txByte), .busyPin(busyPin), .ackNPin(ackNPin),
    .dataIn(dataIn));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ****************************************
  // edge monitor, times in clock edges
  // ****************************************
  always @(posedge core_clk)
  begin
    cyc++;
    if (busyPin && !pBusy) tBusyHi = cyc;
    if (!busyPin && pBusy) tBusyLo = cyc;
    if (!ackNPin && pAck) tAckLo = cyc;
    if (ackNPin && !pAck) tAckHi = cyc;
    if (portOut.dataStbN && !pOut.dataStbN) tRelD = cyc;
    if (portOut.addrStbN && !pOut.addrStbN) tRelA = cyc;
    if (portOut.writeN && !pOut.writeN) tRelW = cyc;
    if (!portOut.ackHsN && pOut.ackHsN) tHsLo = cyc;
    if (portOut.ackHsN && !pOut.ackHsN) tHsHi = cyc;
    if ((!portOut.dataStbN && pOut.dataStbN) || (!portOut.addrStbN && pOut.addrStbN))
    begin
      stbFalls++;
      stbData = portOut.dataOut;
      stbOe = portOut.dataOe;
    end
    if (!portOut.writeN && pOut.writeN && portOut.dataStbN) fwd.push_back(portOut.dataOut);
    if (fwdQueueReady === 1'b0) sawFull = 1'b1;
    pOut = portOut;
    pBusy = busyPin;
    pAck = ackNPin;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hang(input string msg);
    chk(1'b0, msg);
    final_report();
  endtask
  // pin to response: synchroniser adds two edges, sequencer sample one more
  function automatic int lat(input int d);
    return d + 3 + (filterEn ? 2 : 0);
  endfunction
  task automatic wait_rsp(input int n, output logic gd, output logic gr, output int i);
    gd = 1'b0;
    gr = 1'b0;
    i = 0;
    while (gd !== 1'b1 && gr !== 1'b1)
    begin
      if (i == n) hang("no host response");
      tick();
      i++;
      gd = hostRsp.done;
      gr = hostRsp.retry;
    end
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; !(portOut.dataStbN && portOut.addrStbN && portOut.writeN && portOut.ackHsN
        && !busyPin && ackNPin); i++)
    begin
      if (i == 80) hang("port never idle");
      tick();
    end
    repeat (6) tick();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic epp_op(input ppe_pkg::acc_kind_t k, input logic w, input logic [7:0] d,
      input int rel, input bit slow);
    logic gd, gr;
    int n, f0;
    f0 = stbFalls;
    txByte = d;
    hostReq = '{1'b1, w, k, d};
    wait_rsp(40, gd, gr, n);
    if (slow) chk(gr === 1'b1 && n == ppe_pkg::RETRY_CLKS + 1, "no retry on long cycle");
    if (gr === 1'b1)
    begin
      hostReq.valid = 1'b0;
      wait_idle();
      hostReq.valid = 1'b1;
      wait_rsp(4, gd, gr, n);
    end
    chk(gd === 1'b1, "access not completed");
    hostReq.valid = 1'b0;
    if (!w) chk(hostRsp.rdata === d, "read data wrong");
    else chk(stbData === d, "write data wrong");
    wait_idle();
    chk(stbFalls == f0 + 1, "extra port cycle");
    chk(stbOe === w && portOut.dataOe === 1'b0, "data drive enable");
    chk((k == ppe_pkg::ACC_EPP_DATA ? tRelD : tRelA) - tBusyHi == lat(rel), "strobe");
    if (w) chk(tRelW - tBusyLo == lat(int'(ppe_pkg::DLY_END)), "write end");
  endtask
  task automatic ecp_fwd();
    logic gd, gr;
    int n, i;
    sawFull = 1'b0;
    fwd.delete();
    for (i = 0; i < 6; i++)
    begin
      hostReq = '{1'b1, 1'b1, ppe_pkg::ACC_ECP_QUEUE, 8'h10 + i[7:0]};
      wait_rsp(120, gd, gr, n);
      hostReq.valid = 1'b0;
      if (i < 2) chk(n <= 2, "queue write waited on transfer");
      tick();
    end
    chk(sawFull === 1'b1, "queue never filled");
    for (i = 0; fwd.size() < 6; i++)
    begin
      if (i == 300) hang("forward bytes missing");
      tick();
    end
    for (i = 0; i < 6; i++) chk(fwd[i] === 8'h10 + i[7:0], "forward byte order");
    chk(tRelW - tBusyHi == lat(int'(ppe_pkg::DLY_ECP_STB_REL)), "forward strobe");
    wait_idle();
  endtask
  task automatic rev_byte(input logic [7:0] b);
    txByte = b;
    revGo = 1'b1;
    tick();
    revGo = 1'b0;
  endtask
  task automatic q_read(input logic [7:0] exp);
    logic gd, gr;
    int n;
    hostReq = '{1'b1, 1'b0, ppe_pkg::ACC_ECP_QUEUE, 8'h00};
    wait_rsp(8, gd, gr, n);
    hostReq.valid = 1'b0;
    chk(gd === 1'b1 && hostRsp.rdata === exp, "queue read");
    tick();
  endtask
  task automatic ecp_rev();
    reverseMode = 1'b1;
    rev_byte(8'hE1);
    wait_idle();
    chk(tHsLo - tAckLo == lat(int'(ppe_pkg::DLY_REV_ASSERT)), "handshake assert");
    chk(tHsHi - tAckHi == lat(int'(ppe_pkg::DLY_REV_RELEASE)), "handshake release");
    rev_byte(8'h7E);
    wait_idle();
    rev_byte(8'h99);
    q_read(8'hE1);
    wait_idle();
    chk(tHsLo - tAckLo == lat(int'(ppe_pkg::DLY_REV_ASSERT)), "reverse disturbed");
    q_read(8'h7E);
    q_read(8'h99);
    q_read(8'h00);
    reverseMode = 1'b0;
  endtask
  // an access to no target must get no answer and start no port cycle
  task automatic no_target();
    bit bad;
    bad = 1'b0;
    hostReq = '{1'b1, 1'b1, ppe_pkg::ACC_NONE, 8'h00};
    repeat (20)
    begin
      tick();
      bad |= hostRsp.done !== 1'b0 || hostRsp.retry !== 1'b0
        || (portOut.dataStbN & portOut.addrStbN & portOut.writeN) !== 1'b1;
    end
    hostReq.valid = 1'b0;
    chk(!bad, "answer to unmapped access");
  endtask
  initial
  begin
    rstn = 1'b0;
    hostReq = '0;
    filterEn = 1'b0;
    reverseMode = 1'b0;
    dly = 4'h0;
    revGo = 1'b0;
    txByte = 8'h00;
    repeat (8) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (2) tick();
    dly = 4'hA;
    epp_op(ppe_pkg::ACC_EPP_DATA, 1'b1, 8'hA5, int'(ppe_pkg::DLY_DSTB_REL), 1'b1);
    dly = 4'h0;
    epp_op(ppe_pkg::ACC_EPP_DATA, 1'b0, 8'h3C, int'(ppe_pkg::DLY_DSTB_REL), 1'b0);
    epp_op(ppe_pkg::ACC_EPP_ADDR, 1'b1, 8'h5A, int'(ppe_pkg::DLY_ASTB_WR_REL), 1'b0);
    dly = 4'hA;
    epp_op(ppe_pkg::ACC_EPP_ADDR, 1'b0, 8'hC3, int'(ppe_pkg::DLY_ASTB_RD_REL), 1'b1);
    filterEn = 1'b1;
    dly = 4'h2;
    epp_op(ppe_pkg::ACC_EPP_DATA, 1'b1, 8'h96, int'(ppe_pkg::DLY_DSTB_REL), 1'b0);
    filterEn = 1'b0;
    dly = 4'h6;
    ecp_fwd();
    ecp_rev();
    no_target();
    final_report();
  end
endmodule
